// ===== hbc_defs.vh
// constants of the half-bridge input controller
// Operation
// - interlock mode: high strap to 5v rail
// - never change mode while operating
// - no-interlock mode: low strap to 5v rail
// - strap resistor 100 to 220 kilohms
// - only the three defined modes are valid
`ifndef HBC_DEFS_VH
`define HBC_DEFS_VH

// ********************
// register word offsets (byte address = 4 * index)
// ********************
`define HBC_REG_CTRL 3'h0
`define HBC_REG_STATUS 3'h1
`define HBC_REG_PERIOD 3'h2
`define HBC_REG_DUTY 3'h3
`define HBC_REG_DEAD 3'h4
`define HBC_REG_IRQSTAT 3'h5
`define HBC_REG_IRQMASK 3'h6

// ********************
// fields
// ********************
`define HBC_CTRL_RUN 0
`define HBC_CTRL_MODE_LO 1
`define HBC_CTRL_MODE_HI 2
`define HBC_MODE_PWM 2'h0
`define HBC_MODE_IND 2'h1
`define HBC_MODE_IND_LOCK 2'h2
`define HBC_MODE_BAD 2'h3
`define HBC_IRQ_SUPFALL 0
`define HBC_IRQ_SUPRISE 1
`define HBC_IRQ_WRAP 2
`define HBC_IRQ_W 3

// ********************
// reset values
// ********************
`define HBC_PERIOD_RST 16'h0064
`define HBC_DUTY_RST 16'h0032
`define HBC_CLK_NS 10
`define HBC_DT_MIN_NS 5
`define HBC_DT_MIN_CYC ((`HBC_DT_MIN_NS + `HBC_CLK_NS - 1) / `HBC_CLK_NS)
`define HBC_DEAD_RST 8'h02

`endif

// ===== hbc_pwm_gen.v
// period counter producing the control waveform and a wrap pulse
`timescale 1ns/1ps
module hbc_pwm_gen #(
  parameter CW = 16
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // control
  input wire enable,
  input wire [CW-1:0] period,
  input wire [CW-1:0] duty,
  // result
  output reg wave,
  output reg wrap
);

  reg [CW-1:0] cnt_q;
  // a zero period wraps every cycle instead of running to the top
  wire last = (period == {CW{1'b0}}) | (cnt_q >= period - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= {CW{1'b0}};
      wave <= 1'b0;
      wrap <= 1'b0;
    end else if (!enable) begin
      cnt_q <= {CW{1'b0}};
      wave <= 1'b0;
      wrap <= 1'b0;
    end else begin
      cnt_q <= last ? {CW{1'b0}} : cnt_q + {{(CW-1){1'b0}}, 1'b1};
      wave <= (cnt_q < duty);
      wrap <= last;
    end
  end

endmodule

// ===== hbc_controller.v
// controller driving the two logic inputs of a half-bridge gate driver
`timescale 1ns/1ps
`include "hbc_defs.vh"
module hbc_controller #(
  parameter CW = 16,
  parameter DW = 8
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // driver pins
  output reg pwm_low_input,
  output reg enable_high_input,
  input wire supply_ok_flag,
  output reg [1:0] strapSel,
  // interrupt
  output wire irq
);

  // ********************
  // register file
  // ********************
  reg run_q;
  reg [1:0] mode_q;
  reg [CW-1:0] period_q;
  reg [CW-1:0] duty_q;
  reg [DW-1:0] dead_q;
  reg [`HBC_IRQ_W-1:0] irqStat_q;
  reg [`HBC_IRQ_W-1:0] irqMask_q;
  reg supOk_q;

  // ********************
  // request decode
  // ********************
  // ack low in the take keeps a held strobe from being taken twice
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd = req & ~wb_we_i;
  wire [2:0] idx = wb_adr_i[4:2];
  // index 7 and any upper address answer with zero and write nothing
  wire inMap = (wb_adr_i[7:5] == 3'h0) & (idx != 3'h7);
  wire [1:0] newMode = wb_dat_i[`HBC_CTRL_MODE_HI:`HBC_CTRL_MODE_LO];
  // mode that a run request would start with; the held one while running
  wire [1:0] effMode = run_q ? mode_q : newMode;
  wire modeValid = (mode_q != `HBC_MODE_BAD);
  // both pins fall at the edge after any of these drops
  wire active = run_q & supOk_q & modeValid;

  wire wave;
  wire wrap;
  wire supFall = supOk_q & ~supply_ok_flag;
  wire supRise = ~supOk_q & supply_ok_flag;
  wire [`HBC_IRQ_W-1:0] events = {wrap, supRise, supFall};
  wire clrStat = rd & inMap & (idx == `HBC_REG_IRQSTAT);

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= 1'b0;
      mode_q <= `HBC_MODE_PWM;
      period_q <= `HBC_PERIOD_RST;
      duty_q <= `HBC_DUTY_RST;
      dead_q <= `HBC_DEAD_RST;
      irqMask_q <= {`HBC_IRQ_W{1'b0}};
    end else if (wr && inMap) begin
      case (idx)
        `HBC_REG_CTRL: begin
          // mode only moves while stopped, so a write made while running keeps the old one
          if (!run_q) begin
            mode_q <= newMode;
          end
          // an invalid mode can never be started
          run_q <= wb_dat_i[`HBC_CTRL_RUN] & (effMode != `HBC_MODE_BAD);
        end
        `HBC_REG_PERIOD: period_q <= wb_dat_i[CW-1:0];
        `HBC_REG_DUTY: duty_q <= wb_dat_i[CW-1:0];
        `HBC_REG_DEAD: dead_q <= wb_dat_i[DW-1:0];
        `HBC_REG_IRQMASK: irqMask_q <= wb_dat_i[`HBC_IRQ_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // ********************
  // supply tracking and interrupts
  // ********************
  // flag is taken as synchronous, so one register is enough for its edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      supOk_q <= 1'b0;
    end else begin
      supOk_q <= supply_ok_flag;
    end
  end

  // set wins over the read that clears
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat_q <= {`HBC_IRQ_W{1'b0}};
    end else begin
      irqStat_q <= (clrStat ? {`HBC_IRQ_W{1'b0}} : irqStat_q) | events;
    end
  end

  // level output: stays high until software reads the status
  assign irq = |(irqStat_q & irqMask_q);

  // ********************
  // bus answer, one cycle after the request
  // ********************
  reg [31:0] rdData;
  always @* begin
    rdData = 32'h0;
    case (idx)
      `HBC_REG_CTRL: rdData = {29'h0, mode_q, run_q};
      `HBC_REG_STATUS: rdData = {27'h0, mode_q, modeValid, supOk_q, active};
      `HBC_REG_PERIOD: rdData[CW-1:0] = period_q;
      `HBC_REG_DUTY: rdData[CW-1:0] = duty_q;
      `HBC_REG_DEAD: rdData[DW-1:0] = dead_q;
      `HBC_REG_IRQSTAT: rdData[`HBC_IRQ_W-1:0] = irqStat_q;
      `HBC_REG_IRQMASK: rdData[`HBC_IRQ_W-1:0] = irqMask_q;
      default: rdData = 32'h0;
    endcase
    if (!inMap) begin
      rdData = 32'h0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      // unmapped requests are answered as well, so the master never hangs
      wb_ack_o <= req;
      wb_dat_o <= rd ? rdData : 32'h0;
    end
  end

  // ********************
  // waveform source
  // ********************
  hbc_pwm_gen #(
    .CW(CW)
  ) u_gen (
    .clk(clk),
    .reset_n(reset_n),
    .enable(active),
    .period(period_q),
    .duty(duty_q),
    .wave(wave),
    .wrap(wrap)
  );

  // ********************
  // strap select
  // ********************
  // follows the mode register, which only moves while stopped, so the
  // board straps never change under a running driver
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strapSel <= `HBC_MODE_PWM;
    end else begin
      strapSel <= mode_q;
    end
  end

  // ********************
  // pin drive
  // ********************
  // independent modes: host inserts its own gap on every edge, since with
  // interlock off nothing else prevents shoot-through
  reg prevWave_q;
  reg [DW-1:0] dtCnt_q;
  // the shortest gap is rounded up to whole clock cycles
  wire [31:0] dtMinFull = `HBC_DT_MIN_CYC;
  wire [DW-1:0] dtMin = dtMinFull[DW-1:0];
  wire [DW-1:0] dtLoad = (dead_q < dtMin) ? dtMin : dead_q;
  wire edgeSeen = (wave != prevWave_q);
  wire dtDone = (dtCnt_q == {DW{1'b0}});

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevWave_q <= 1'b0;
      dtCnt_q <= {DW{1'b0}};
      pwm_low_input <= 1'b0;
      enable_high_input <= 1'b0;
    end else begin
      prevWave_q <= wave;
      if (!active) begin
        // lockout or invalid mode: both inputs low
        dtCnt_q <= {DW{1'b0}};
        pwm_low_input <= 1'b0;
        enable_high_input <= 1'b0;
      end else if (mode_q == `HBC_MODE_PWM) begin
        // driver makes the complementary pair and its own dead time
        enable_high_input <= 1'b1;
        pwm_low_input <= wave;
      end else if (edgeSeen) begin
        // every transition first drops both inputs, so a clean edge follows
        dtCnt_q <= dtLoad;
        pwm_low_input <= 1'b0;
        enable_high_input <= 1'b0;
      end else if (!dtDone) begin
        dtCnt_q <= dtCnt_q - {{(DW-1){1'b0}}, 1'b1};
      end else begin
        // never both high, so the driver interlock stays idle
        enable_high_input <= wave;
        pwm_low_input <= ~wave;
      end
    end
  end

endmodule

// ===== hbc_ctl_monitor.sv
// assertion checker for the half-bridge controller ports
`timescale 1ns/1ps
module hbc_ctl_monitor (
  // clock and bus
  input wire clk,
  input wire reset_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // driver pins
  input wire pwm_low_input,
  input wire enable_high_input,
  input wire supply_ok_flag,
  input wire [1:0] strapSel
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // dead band after a falling edge
  sequence sGap;
    !enable_high_input ##1 !enable_high_input;
  endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_flag_stop: assert property (!supply_ok_flag |-> ##2 !pwm_low_input && !enable_high_input)
    else $error("pins active after supply fell");
  a_never_both: assert property (strapSel != 2'h0 |-> !(pwm_low_input && enable_high_input))
    else $error("both inputs high");
  a_pwm_enable: assert property (strapSel == 2'h0 && pwm_low_input |-> enable_high_input)
    else $error("waveform without enable");
  a_iim_gap: assert property (strapSel != 2'h0 && $fell(pwm_low_input) |-> sGap)
    else $error("dead band too short");
endmodule
bind hbc_controller hbc_ctl_monitor uMon (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pwm_low_input(pwm_low_input),
  .enable_high_input(enable_high_input), .supply_ok_flag(supply_ok_flag), .strapSel(strapSel));

// ===== hbc_drv_model.sv
// behavioural model of the gate driver logic
`timescale 1ns/1ps
module hbc_drv_model #(
  parameter DT_LH_NS = 5,
  parameter DT_HL_NS = 5
) (
  // inputs and strap
  input wire pwm_low_input,
  input wire enable_high_input,
  input wire [1:0] strapSel,
  // supply state
  input wire lsGood,
  input wire hsGood,
  // outputs
  output wire high_side_output,
  output wire low_side_output,
  output wire supply_ok_flag
);
  wire pwmMode = (strapSel == 2'h0);
  wire valid = (strapSel != 2'h3);
  // no deglitch: blanking tracks input edges at once
  wire lockOff = (strapSel == 2'h2) & pwm_low_input & enable_high_input;
  // pwm mode: each turn-on waits its own dead time after the waveform edge
  wire lhLate;
  wire hlLate;
  assign #(DT_LH_NS) lhLate = pwm_low_input;
  assign #(DT_HL_NS) hlLate = pwm_low_input;
  wire hiPwm = enable_high_input & pwm_low_input & lhLate;
  wire loPwm = enable_high_input & ~pwm_low_input & ~hlLate;
  wire hiRaw = pwmMode ? hiPwm : enable_high_input;
  wire loRaw = pwmMode ? loPwm : pwm_low_input;
  assign high_side_output = lsGood & hsGood & valid & ~lockOff & hiRaw;
  assign low_side_output = lsGood & valid & ~lockOff & loRaw;
  assign supply_ok_flag = lsGood;
endmodule

// ===== tb.sv
// testbench for the half-bridge controller
`timescale 1ns/1ps
module tb;
  reg clk = 0, reset_n = 0, cyc = 0, we = 0, lsGood = 1, hsGood = 1;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h0, rdat;
  wire [31:0] datO;
  wire ack, pwm, en, flag, irq, ho, lo;
  wire [1:0] strap;
  integer mismatches = 0, check_count = 0, nh, nl, ne;
  hbc_controller DUT (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .irq(irq),
    .pwm_low_input(pwm), .enable_high_input(en), .supply_ok_flag(flag), .strapSel(strap));
  hbc_drv_model uDrv (.pwm_low_input(pwm), .enable_high_input(en), .strapSel(strap), .lsGood(lsGood),
    .hsGood(hsGood), .high_side_output(ho), .low_side_output(lo), .supply_ok_flag(flag));
  initial forever #5 clk = ~clk;
  task close_out;
    begin
      if (mismatches == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle; the next call waits an edge so cyc stays low a cycle
  task bus(input w, input [2:0] idx, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1; we <= w; adr <= {3'h0, idx, 2'h0}; dat <= d;
      @(posedge clk);
      while (ack !== 1'b1) begin
        @(posedge clk);
      end
      rdat = datO;
      cyc <= 1'b0;
    end
  endtask
  task measure;
    begin
      nh = 0; nl = 0; ne = 0;
      repeat (20) begin
        @(posedge clk);
        nh = nh + ho; nl = nl + lo; ne = ne + en;
      end
    end
  endtask
  initial begin
    #20000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, 2, 0); chk(rdat, 32'h64);
    bus(0, 3, 0); chk(rdat, 32'h32);
    bus(0, 4, 0); chk(rdat, 32'h2);
    bus(0, 7, 0); chk(rdat, 32'h0);
    bus(1, 6, 32'h3); @(posedge clk); chk({31'h0, irq}, 32'h1);
    bus(0, 5, 0); chk(rdat, 32'h2); @(posedge clk); chk({31'h0, irq}, 32'h0);
    bus(1, 2, 32'ha); bus(1, 3, 32'h4); bus(1, 0, 32'h1); repeat (12) @(posedge clk);
    measure; chk(nh, 8); chk(nl, 12);
    lsGood <= 1'b0; repeat (3) @(posedge clk);
    measure; chk(ne, 0); chk({31'h0, irq}, 32'h1);
    lsGood <= 1'b1; hsGood <= 1'b0; repeat (12) @(posedge clk);
    measure; chk(nh, 0); chk(nl, 12);
    hsGood <= 1'b1; bus(0, 5, 0); chk(rdat & 32'h3, 32'h3);
    bus(1, 0, 32'h0); bus(1, 0, 32'h5); repeat (12) @(posedge clk);
    measure; chk(nh, 2); chk(nl, 6); chk({30'h0, strap}, 32'h2);
    bus(1, 0, 32'h3); bus(0, 0, 0); chk(rdat, 32'h5);
    bus(1, 0, 32'h0); bus(1, 0, 32'h3); repeat (12) @(posedge clk);
    measure; chk(nh, 2); chk(nl, 6); chk({30'h0, strap}, 32'h1);
    bus(1, 0, 32'h0); bus(1, 0, 32'h7); bus(0, 0, 0); chk(rdat, 32'h6);
    bus(0, 1, 0); chk(rdat, 32'h1a); chk({30'h0, strap}, 32'h3);
    measure; chk(nh + nl, 0);
    close_out;
  end
endmodule
